//--- rtl/tppc_pkg.sv
// Shared constants and types for the Type-C port policy control block
package tppc_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_KHZ = 20000;
   // Attach debounce time in microseconds; plain default, tune per system
   localparam int CC_DEBOUNCE_US = 150;
   // Least time, rounded up to whole cycles
   localparam int CC_DEBOUNCE_CYC = (CC_DEBOUNCE_US * CLK_FREQ_KHZ + 999) / 1000;
   localparam int DEB_CNT_W = 12;
   localparam logic [DEB_CNT_W-1:0] DEB_CNT_RST = 12'h000;
   localparam logic [DEB_CNT_W-1:0] DEB_LAST = DEB_CNT_W'(CC_DEBOUNCE_CYC - 1);

   // ----------------------------------------------------------------
   // Synchroniser bus bit positions
   // ----------------------------------------------------------------
   localparam int SYNC_W = 11;
   localparam int SB_SEL_HI = 0;
   localparam int SB_SEL_LO = 1;
   localparam int SB_VARIANT = 2;
   localparam int SB_CC1_RD = 3;
   localparam int SB_CC1_RA = 4;
   localparam int SB_CC2_RD = 5;
   localparam int SB_CC2_RA = 6;
   localparam int SB_DIE_HOT = 7;
   localparam int SB_DIE_COOL = 8;
   localparam int SB_HEAT_WARN = 9;
   localparam int SB_THERM_OFF = 10;

   // ----------------------------------------------------------------
   // Configuration pin patterns {sel_hi, sel_lo}
   // ----------------------------------------------------------------
   localparam logic [1:0] CFG_DCP_AUTO = 2'h1;
   localparam logic [1:0] CFG_SDP = 2'h2;
   localparam logic [1:0] CFG_CDP = 2'h3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ADV_DEFAULT = 2'h0,
      ADV_1A5 = 2'h1,
      ADV_3A0 = 2'h2
   } tppc_adv_type;

   typedef enum logic [1:0] {
      MODE_NONE = 2'h0,
      MODE_SDP = 2'h1,
      MODE_CDP = 2'h2,
      MODE_DCP_AUTO = 2'h3
   } tppc_usb_mode_type;

   typedef enum logic [2:0] {
      ATT_IDLE = 3'h1,
      ATT_DEBOUNCE = 3'h2,
      ATT_ATTACHED = 3'h4
   } tppc_att_state_type;

   typedef enum logic [2:0] {
      PWR_OFF = 3'h1,
      PWR_ON = 3'h2,
      PWR_DIE_HOT = 3'h4
   } tppc_pwr_state_type;

endpackage

//--- rtl/tppc_cc_if.sv
// Interface carrying CC levels to the attach detector and its results back
`timescale 1ns/10ps
interface tppc_cc_if;
   logic [1:0] rd;
   logic [1:0] ra;
   logic attached;
   logic sink_on_cc2;
   logic accessory;
   logic [1:0] vconn_req;

   modport src (output rd, output ra, input attached, input sink_on_cc2, input accessory, input vconn_req);
   modport det (input rd, input ra, output attached, output sink_on_cc2, output accessory, output vconn_req);
endinterface

//--- rtl/tppc_sync.sv
// Two-stage synchroniser for a bus of independent single-bit levels
`timescale 1ns/10ps
module tppc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Levels
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               meta_r[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               meta_r[i] <= async_in[i];
               sync_out[i] <= meta_r[i];
            end
         end
      end
   endgenerate
endmodule

//--- rtl/tppc_cc_detect.sv
// Sink attach detector with debounce, accessory rejection and VCONN side
`timescale 1ns/10ps
module tppc_cc_detect
   import tppc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // CC levels and results
   tppc_cc_if.det cc
);
   tppc_att_state_type state_r, state_nxt;
   logic [DEB_CNT_W-1:0] cnt_r;
   logic side_r;

   // Accessory if both pins show the same termination class
   wire accessory_w = (cc.rd == 2'h3) | (cc.ra == 2'h3);
   wire one_sink_w = (cc.rd[0] ^ cc.rd[1]) & ~accessory_w;
   wire side_w = cc.rd[1];
   // A side swap restarts the debounce, so a flipping plug never attaches
   wire valid_w = one_sink_w & (state_r == ATT_IDLE || side_w == side_r);
   wire deb_done_w = (cnt_r == DEB_LAST);

   always_comb begin
      case (state_r)
         ATT_IDLE: state_nxt = one_sink_w ? ATT_DEBOUNCE : ATT_IDLE;
         ATT_DEBOUNCE: state_nxt = !valid_w ? ATT_IDLE : (deb_done_w ? ATT_ATTACHED : ATT_DEBOUNCE);
         ATT_ATTACHED: state_nxt = valid_w ? ATT_ATTACHED : ATT_IDLE;
         default: state_nxt = ATT_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ATT_IDLE;
         cnt_r <= DEB_CNT_RST;
         side_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= (state_r == ATT_DEBOUNCE) ? cnt_r + 1'b1 : DEB_CNT_RST; // [RL13]
         if (state_r == ATT_IDLE) begin
            side_r <= side_w;
         end
      end
   end

   assign cc.attached = (state_r == ATT_ATTACHED); // [RL13]
   assign cc.sink_on_cc2 = side_r;
   assign cc.accessory = accessory_w; // [RL4]
   // Cable termination on the pin opposite the sink
   assign cc.vconn_req = {cc.ra[1] & ~side_r, cc.ra[0] & side_r} & {2{cc.attached}}; // [RL14]
endmodule

//--- rtl/tppc_top.sv
// Type-C downstream port policy control: config decode, attach, thermal gating
// ----------------------------------------------------------------
// Notes on behaviour
// [RL1] Select pins 1,0 give 1.5 A with SDP; 1,1 give 3 A with CDP.
// [RL2] Thermistor variant: 0,1 gives 3 A automatic DCP, no USB 2.0 data.
// [RL3] Output current limit follows the advertised current level.
// [RL4] Rd on both or Ra on both pins is an accessory; power stays off.
// [RL5] Orientation and load flags only pull low or release, never drive high.
// [RL6] Without an attached sink the orientation flag stays released.
// [RL7] Sink on CC1 releases orientation flag; sink on CC2 pulls it low.
// [RL8] Bus stays unpowered with regulator off until a sink is detected.
// [RL9] Die overtemperature stops regulator and gate until die cools, then restarts.
// [RL10] Thermistor warning lowers a 3 A advertisement to 1.5 A.
// [RL11] Thermistor warning raises the overheat flag but never the fault output.
// [RL12] Thermistor shutdown turns regulator and gate off; warning stays, no fault.
// [RL13] Regulator turns on only after the attach debounce time has elapsed.
// [RL14] VCONN goes to the pin showing cable termination opposite the sink.
// [RL15] All comparator results enter the logic through two-stage synchronisers.
// [RL16] Thermal shutdowns override attach; regulator enable is attach, valid config and no shutdown.
// ----------------------------------------------------------------
`timescale 1ns/10ps
module tppc_top
   import tppc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Configuration pins from the host system
   input wire logic port_cfg_sel_hi,
   input wire logic port_cfg_sel_lo,
   input wire logic thermistor_variant,
   // CC termination comparators
   input wire logic cc1_rd_det,
   input wire logic cc1_ra_det,
   input wire logic cc2_rd_det,
   input wire logic cc2_ra_det,
   // Thermal comparators
   input wire logic die_overtemp_limit,
   input wire logic die_temp_recovered,
   input wire logic thermistor_sense_warn,
   input wire logic thermistor_sense_off,
   // Power path controls
   output logic regulator_en,
   output logic bus_switch_gate,
   output logic bus_switch_gate_alt,
   output logic vconn_cc1_en,
   output logic vconn_cc2_en,
   // Advertisement and charging mode
   output tppc_adv_type cc_adv_level,
   output tppc_adv_type current_limit_sel,
   output tppc_usb_mode_type usb_mode,
   output logic usb_data_pass,
   output logic cfg_reserved,
   // Orientation open-drain flag
   input wire logic orientation_flag_n_in,
   output logic orientation_flag_n_out,
   output logic orientation_flag_n_oe_n,
   // Load-detect open-drain flag
   input wire logic load_present_n_in,
   output logic load_present_n_out,
   output logic load_present_n_oe_n,
   // Status flags
   output logic overheat_warning,
   output logic fault_flag
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] raw_w;
   logic [SYNC_W-1:0] s_w;

   assign raw_w[SB_SEL_HI] = port_cfg_sel_hi;
   assign raw_w[SB_SEL_LO] = port_cfg_sel_lo;
   assign raw_w[SB_VARIANT] = thermistor_variant;
   assign raw_w[SB_CC1_RD] = cc1_rd_det;
   assign raw_w[SB_CC1_RA] = cc1_ra_det;
   assign raw_w[SB_CC2_RD] = cc2_rd_det;
   assign raw_w[SB_CC2_RA] = cc2_ra_det;
   assign raw_w[SB_DIE_HOT] = die_overtemp_limit;
   assign raw_w[SB_DIE_COOL] = die_temp_recovered;
   assign raw_w[SB_HEAT_WARN] = thermistor_sense_warn;
   assign raw_w[SB_THERM_OFF] = thermistor_sense_off;

   // Every comparator and pin is a level from outside this clock
   tppc_sync #(.W(SYNC_W)) u_sync ( // [RL15]
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in(raw_w),
      .sync_out(s_w)
   );

   // ----------------------------------------------------------------
   // Attach detection
   // ----------------------------------------------------------------
   tppc_cc_if cc_bus ();

   assign cc_bus.rd = {s_w[SB_CC2_RD], s_w[SB_CC1_RD]};
   assign cc_bus.ra = {s_w[SB_CC2_RA], s_w[SB_CC1_RA]};

   tppc_cc_detect u_detect (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .cc(cc_bus.det)
   );

   wire attached_w = cc_bus.attached;
   wire sink_cc2_w = cc_bus.sink_on_cc2;
   wire accessory_w = cc_bus.accessory;

   // ----------------------------------------------------------------
   // Configuration decode
   // ----------------------------------------------------------------
   wire [1:0] cfg_w = {s_w[SB_SEL_HI], s_w[SB_SEL_LO]};
   wire variant_w = s_w[SB_VARIANT];
   wire is_sdp_w = (cfg_w == CFG_SDP);
   wire is_cdp_w = (cfg_w == CFG_CDP);
   wire is_dcp_w = (cfg_w == CFG_DCP_AUTO) & variant_w; // [RL2]
   // Reserved patterns keep the port unpowered rather than guess a level
   wire cfg_ok_w = is_sdp_w | is_cdp_w | is_dcp_w; // [RL1]

   tppc_adv_type base_adv_w;
   tppc_adv_type eff_adv_w;
   tppc_usb_mode_type mode_w;

   assign base_adv_w = is_sdp_w ? ADV_1A5 : ((is_cdp_w | is_dcp_w) ? ADV_3A0 : ADV_DEFAULT); // [RL1] [RL2]
   assign mode_w = is_sdp_w ? MODE_SDP : (is_cdp_w ? MODE_CDP : (is_dcp_w ? MODE_DCP_AUTO : MODE_NONE));
   // Automatic DCP shorts the data lines locally, so no USB 2.0 pass-through
   wire data_pass_w = is_sdp_w | is_cdp_w; // [RL2]

   // ----------------------------------------------------------------
   // Thermistor levels
   // ----------------------------------------------------------------
   // Only the variant with a thermistor input acts on these comparators
   wire therm_off_w = variant_w & s_w[SB_THERM_OFF];
   // The shutdown level lies above the warning level, so it implies the warning
   wire heat_warn_w = variant_w & (s_w[SB_HEAT_WARN] | s_w[SB_THERM_OFF]); // [RL11] [RL12]

   assign eff_adv_w = (base_adv_w == ADV_3A0 && heat_warn_w) ? ADV_1A5 : base_adv_w; // [RL10]

   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------
   tppc_pwr_state_type pwr_r, pwr_nxt;

   wire die_hot_w = s_w[SB_DIE_HOT];
   // Restart needs the hysteresis comparator set and the limit cleared
   wire die_cool_w = s_w[SB_DIE_COOL] & ~die_hot_w; // [RL9]
   wire may_source_w = attached_w & cfg_ok_w & ~accessory_w & ~therm_off_w; // [RL4] [RL8] [RL12] [RL16]

   always_comb begin
      case (pwr_r)
         PWR_OFF: begin
            if (die_hot_w) begin
               pwr_nxt = PWR_DIE_HOT; // [RL16]
            end else if (may_source_w) begin
               pwr_nxt = PWR_ON; // [RL8]
            end else begin
               pwr_nxt = PWR_OFF;
            end
         end
         PWR_ON: begin
            if (die_hot_w) begin
               pwr_nxt = PWR_DIE_HOT; // [RL9]
            end else if (!may_source_w) begin
               pwr_nxt = PWR_OFF; // [RL12]
            end else begin
               pwr_nxt = PWR_ON;
            end
         end
         PWR_DIE_HOT: begin
            // Restart attempt goes through OFF so attach is checked afresh
            pwr_nxt = die_cool_w ? PWR_OFF : PWR_DIE_HOT; // [RL9]
         end
         default: pwr_nxt = PWR_OFF;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pwr_r <= PWR_OFF;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

   wire power_on_w = (pwr_nxt == PWR_ON); // [RL16]

   // ----------------------------------------------------------------
   // Power path outputs
   // ----------------------------------------------------------------
   // VCONN is only offered while the port is actively sourcing the bus
   wire vconn1_w = power_on_w & cc_bus.vconn_req[0]; // [RL14]
   wire vconn2_w = power_on_w & cc_bus.vconn_req[1]; // [RL14]

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         regulator_en <= 1'b0;
         bus_switch_gate <= 1'b0;
         bus_switch_gate_alt <= 1'b0;
         vconn_cc1_en <= 1'b0;
         vconn_cc2_en <= 1'b0;
      end else begin
         regulator_en <= power_on_w; // [RL8] [RL9] [RL12] [RL13]
         bus_switch_gate <= power_on_w; // [RL4] [RL9] [RL12]
         bus_switch_gate_alt <= power_on_w; // [RL9]
         vconn_cc1_en <= vconn1_w;
         vconn_cc2_en <= vconn2_w;
      end
   end

   // ----------------------------------------------------------------
   // Advertisement and mode outputs
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cc_adv_level <= ADV_DEFAULT;
         current_limit_sel <= ADV_DEFAULT;
         usb_mode <= MODE_NONE;
         usb_data_pass <= 1'b0;
         cfg_reserved <= 1'b0;
      end else begin
         cc_adv_level <= eff_adv_w; // [RL1] [RL10]
         // Limit tracks the level actually advertised, including derating
         current_limit_sel <= eff_adv_w; // [RL3]
         usb_mode <= mode_w; // [RL1] [RL2]
         usb_data_pass <= data_pass_w;
         cfg_reserved <= ~cfg_ok_w;
      end
   end

   // ----------------------------------------------------------------
   // Open-drain flags and status
   // ----------------------------------------------------------------
   // Flags pull low only while a debounced sink is present
   wire orient_pull_w = attached_w & sink_cc2_w & ~accessory_w; // [RL6] [RL7]
   wire load_pull_w = attached_w & ~accessory_w; // [RL4]

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         orientation_flag_n_out <= 1'b0;
         orientation_flag_n_oe_n <= 1'b1;
         load_present_n_out <= 1'b0;
         load_present_n_oe_n <= 1'b1;
         overheat_warning <= 1'b0;
         fault_flag <= 1'b0;
      end else begin
         // Driven level is always low; only the enable moves
         orientation_flag_n_out <= 1'b0; // [RL5]
         orientation_flag_n_oe_n <= ~orient_pull_w; // [RL5] [RL7]
         load_present_n_out <= 1'b0; // [RL5]
         load_present_n_oe_n <= ~load_pull_w; // [RL5]
         overheat_warning <= heat_warn_w; // [RL11] [RL12]
         // Fault reports die overtemperature only, never thermistor events
         fault_flag <= (pwr_nxt == PWR_DIE_HOT); // [RL11] [RL12]
      end
   end

endmodule

//--- tb/tppc_top_props.sv
// Concurrent checks on the port policy control block ports
`timescale 1ns/10ps
module tppc_top_props
   import tppc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Watched inputs
   input wire logic port_cfg_sel_hi,
   input wire logic port_cfg_sel_lo,
   input wire logic thermistor_variant,
   input wire logic cc1_rd_det,
   input wire logic cc2_rd_det,
   input wire logic die_overtemp_limit,
   input wire logic thermistor_sense_warn,
   input wire logic thermistor_sense_off,
   // Watched outputs
   input wire logic regulator_en,
   input wire logic bus_switch_gate,
   input wire logic bus_switch_gate_alt,
   input wire logic vconn_cc1_en,
   input wire logic vconn_cc2_en,
   input wire tppc_adv_type cc_adv_level,
   input wire tppc_adv_type current_limit_sel,
   input wire tppc_usb_mode_type usb_mode,
   input wire logic usb_data_pass,
   input wire logic orientation_flag_n_out,
   input wire logic orientation_flag_n_oe_n,
   input wire logic load_present_n_out,
   input wire logic load_present_n_oe_n,
   input wire logic overheat_warning,
   input wire logic fault_flag
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // ----------------------------------------------------------------
   // Run length of a steady single-sided sink pull-down
   // ----------------------------------------------------------------
   logic [15:0] rd_run_r;
   logic [15:0] rd_run_nxt;
   logic [1:0] rd_prev_r;
   wire rd_steady = (cc1_rd_det ^ cc2_rd_det) && (rd_prev_r == {cc1_rd_det, cc2_rd_det});
   assign rd_run_nxt = rd_steady ? rd_run_r + 16'h0001 : 16'h0000;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_run_r <= 16'h0000;
         rd_prev_r <= 2'h0;
      end else begin
         rd_run_r <= rd_run_nxt;
         rd_prev_r <= {cc1_rd_det, cc2_rd_det};
      end
   end
   // ----------------------------------------------------------------
   // Sequences and properties
   // ----------------------------------------------------------------
   // Derating is excluded so the 3 A check only sees an unloaded sensor
   sequence s_cdp_held;
      ({port_cfg_sel_hi, port_cfg_sel_lo} == CFG_CDP && !(thermistor_variant && (thermistor_sense_warn ||
         thermistor_sense_off)))[*4];
   endsequence
   sequence s_warn_held;
      (thermistor_variant && thermistor_sense_warn)[*4];
   endsequence
   property p_cdp;
      s_cdp_held |-> cc_adv_level == ADV_3A0 && usb_mode == MODE_CDP && usb_data_pass;
   endproperty
   property p_sdp;
      ({port_cfg_sel_hi, port_cfg_sel_lo} == CFG_SDP)[*4] |-> cc_adv_level == ADV_1A5 && usb_mode == MODE_SDP;
   endproperty
   property p_limit;
      current_limit_sel == cc_adv_level;
   endproperty
   property p_accessory;
      (cc1_rd_det && cc2_rd_det)[*5] |-> !regulator_en && load_present_n_oe_n && orientation_flag_n_oe_n;
   endproperty
   property p_open_drain;
      orientation_flag_n_out == 1'b0 && load_present_n_out == 1'b0;
   endproperty
   property p_idle_dir;
      load_present_n_oe_n |-> orientation_flag_n_oe_n;
   endproperty
   property p_power;
      regulator_en |-> !load_present_n_oe_n && !fault_flag;
   endproperty
   property p_gate;
      regulator_en == bus_switch_gate && bus_switch_gate == bus_switch_gate_alt;
   endproperty
   property p_die_hot;
      die_overtemp_limit[*4] |-> !regulator_en && !bus_switch_gate_alt && fault_flag;
   endproperty
   property p_warn;
      s_warn_held |-> cc_adv_level != ADV_3A0 && overheat_warning;
   endproperty
   property p_therm_off;
      (thermistor_variant && thermistor_sense_off)[*4] |-> !regulator_en && !bus_switch_gate && overheat_warning;
   endproperty
   property p_vconn;
      vconn_cc1_en || vconn_cc2_en |-> regulator_en && (vconn_cc1_en ^ vconn_cc2_en) &&
         vconn_cc2_en == orientation_flag_n_oe_n;
   endproperty
   property p_debounce;
      $rose(regulator_en) |-> rd_run_r >= 16'(CC_DEBOUNCE_CYC + 3);
   endproperty
   a_cdp: assert property (p_cdp) else $error("3 A CDP pattern not decoded");
   a_sdp: assert property (p_sdp) else $error("1.5 A SDP pattern not decoded");
   a_limit: assert property (p_limit) else $error("current limit differs from advertisement");
   a_accessory: assert property (p_accessory) else $error("accessory powered");
   a_open_drain: assert property (p_open_drain) else $error("flag driven high");
   a_idle_dir: assert property (p_idle_dir) else $error("orientation asserted without sink");
   a_power: assert property (p_power) else $error("regulator on without sink");
   a_gate: assert property (p_gate) else $error("gate differs from regulator");
   a_die_hot: assert property (p_die_hot) else $error("die overtemperature ignored");
   a_warn: assert property (p_warn) else $error("thermistor warning not derating");
   a_therm_off: assert property (p_therm_off) else $error("thermistor shutdown ignored");
   a_vconn: assert property (p_vconn) else $error("vconn on wrong pin");
   a_debounce: assert property (p_debounce) else $error("regulator on before debounce");
endmodule
bind tppc_top tppc_top_props tppc_top_props_inst (.sys_clk, .sys_rst, .port_cfg_sel_hi, .port_cfg_sel_lo,
   .thermistor_variant, .cc1_rd_det, .cc2_rd_det, .die_overtemp_limit, .thermistor_sense_warn, .thermistor_sense_off,
   .regulator_en, .bus_switch_gate, .bus_switch_gate_alt, .vconn_cc1_en, .vconn_cc2_en, .cc_adv_level,
   .current_limit_sel, .usb_mode, .usb_data_pass, .orientation_flag_n_out, .orientation_flag_n_oe_n,
   .load_present_n_out, .load_present_n_oe_n, .overheat_warning, .fault_flag);

//--- tb/tppc_sink_model.sv
// Behavioural Type-C sink and cable on the CC comparator levels
`timescale 1ns/10ps
module tppc_sink_model (
   // Attachment chosen by the bench
   input wire logic [2:0] plug_kind,
   // CC comparator levels
   output logic cc1_rd_det,
   output logic cc1_ra_det,
   output logic cc2_rd_det,
   output logic cc2_ra_det
);
   // ----------------------------------------------------------------
   // 0 open, 1 sink CC1, 2 sink CC2, 3 sink CC1 cable CC2,
   // 4 cable CC1 sink CC2, 5 Rd both, 6 Ra both, 7 cable only
   // ----------------------------------------------------------------
   always_comb begin
      {cc1_rd_det, cc1_ra_det, cc2_rd_det, cc2_ra_det} = 4'h0;
      case (plug_kind)
         3'h1: cc1_rd_det = 1'b1;
         3'h2: cc2_rd_det = 1'b1;
         3'h3: {cc1_rd_det, cc2_ra_det} = 2'h3;
         3'h4: {cc1_ra_det, cc2_rd_det} = 2'h3;
         3'h5: {cc1_rd_det, cc2_rd_det} = 2'h3;
         3'h6: {cc1_ra_det, cc2_ra_det} = 2'h3;
         3'h7: cc2_ra_det = 1'b1;
         default: cc1_rd_det = 1'b0;
      endcase
   end
endmodule

//--- tb/tppc_top_bench.sv
// Self-checking bench for the Type-C port policy control block
`timescale 1ns/10ps
module tppc_top_bench;
   import tppc_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic port_cfg_sel_hi, port_cfg_sel_lo, thermistor_variant, die_overtemp_limit, die_temp_recovered;
   logic thermistor_sense_warn, thermistor_sense_off;
   logic [2:0] plug_kind;
   logic cc1_rd_det, cc1_ra_det, cc2_rd_det, cc2_ra_det;
   logic regulator_en, bus_switch_gate, bus_switch_gate_alt, vconn_cc1_en, vconn_cc2_en, usb_data_pass, cfg_reserved;
   tppc_adv_type cc_adv_level, current_limit_sel;
   tppc_usb_mode_type usb_mode;
   logic orientation_flag_n_out, orientation_flag_n_oe_n, load_present_n_out, load_present_n_oe_n;
   logic overheat_warning, fault_flag;
   int n_mismatch = 0;
   int check_count = 0;
   // Both flag pins carry pull-ups
   wire orientation_flag_n_in = orientation_flag_n_oe_n ? 1'b1 : orientation_flag_n_out;
   wire load_present_n_in = load_present_n_oe_n ? 1'b1 : load_present_n_out;
   always #25 sys_clk = ~sys_clk;
   tppc_sink_model tppc_sink_model_inst (.plug_kind, .cc1_rd_det, .cc1_ra_det, .cc2_rd_det, .cc2_ra_det);
   tppc_top tppc_top_inst (.sys_clk, .sys_rst, .port_cfg_sel_hi, .port_cfg_sel_lo, .thermistor_variant,
      .cc1_rd_det, .cc1_ra_det, .cc2_rd_det, .cc2_ra_det, .die_overtemp_limit, .die_temp_recovered,
      .thermistor_sense_warn, .thermistor_sense_off, .regulator_en, .bus_switch_gate, .bus_switch_gate_alt,
      .vconn_cc1_en, .vconn_cc2_en, .cc_adv_level, .current_limit_sel, .usb_mode, .usb_data_pass, .cfg_reserved,
      .orientation_flag_n_in, .orientation_flag_n_out, .orientation_flag_n_oe_n, .load_present_n_in,
      .load_present_n_out, .load_present_n_oe_n, .overheat_warning, .fault_flag);
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_config;
      logic [1:0] adv;
      logic [1:0] md;
      for (int i = 0; i < 8; i++) begin
         {thermistor_variant, port_cfg_sel_hi, port_cfg_sel_lo} = 3'(i);
         cyc(5);
         case (i[1:0])
            2'h2: {adv, md} = {ADV_1A5, MODE_SDP};
            2'h3: {adv, md} = {ADV_3A0, MODE_CDP};
            2'h1: {adv, md} = i[2] ? {ADV_3A0, MODE_DCP_AUTO} : {ADV_DEFAULT, MODE_NONE};
            default: {adv, md} = {ADV_DEFAULT, MODE_NONE};
         endcase
         chk("adv", adv, cc_adv_level);
         chk("limit", adv, current_limit_sel);
         chk("mode", md, usb_mode);
         chk("data", md == MODE_SDP || md == MODE_CDP, usb_data_pass);
         chk("resv", md == MODE_NONE, cfg_reserved);
      end
   endtask
   task automatic t_attach(input logic [2:0] kind, input logic on, input logic dir_low, input logic [1:0] vc);
      plug_kind = kind;
      cyc(2900);
      chk("early", 1'b0, regulator_en);
      chk("early dir", 1'b1, orientation_flag_n_in);
      cyc(200);
      chk("reg", on, regulator_en);
      chk("gate", {on, on}, {bus_switch_gate, bus_switch_gate_alt});
      chk("load", !on, load_present_n_in);
      chk("dir", !dir_low, orientation_flag_n_in);
      chk("vconn", vc, {vconn_cc1_en, vconn_cc2_en});
      plug_kind = 3'h0;
      cyc(6);
      chk("off", 1'b0, regulator_en);
      chk("idle dir", 1'b1, orientation_flag_n_in);
   endtask
   task automatic t_thermal;
      plug_kind = 3'h1;
      cyc(3100);
      thermistor_sense_warn = 1'b1;
      cyc(5);
      chk("derate", ADV_1A5, cc_adv_level);
      chk("derate lim", ADV_1A5, current_limit_sel);
      chk("warn", 3'h6, {regulator_en, overheat_warning, fault_flag});
      thermistor_sense_off = 1'b1;
      cyc(5);
      chk("therm off", 4'h2, {regulator_en, bus_switch_gate, overheat_warning, fault_flag});
      {thermistor_sense_warn, thermistor_sense_off} = 2'h0;
      cyc(5);
      chk("resume", 3'h7, {regulator_en, bus_switch_gate, cc_adv_level == ADV_3A0});
      die_overtemp_limit = 1'b1;
      cyc(5);
      chk("hot", 3'h1, {regulator_en, bus_switch_gate, fault_flag});
      die_overtemp_limit = 1'b0;
      cyc(10);
      chk("cooling", 1'b0, regulator_en);
      die_temp_recovered = 1'b1;
      cyc(8);
      chk("restart", 2'h2, {regulator_en, fault_flag});
      die_temp_recovered = 1'b0;
      plug_kind = 3'h0;
      cyc(6);
   endtask
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      {port_cfg_sel_hi, port_cfg_sel_lo, thermistor_variant} = 3'h6;
      {die_overtemp_limit, die_temp_recovered, thermistor_sense_warn, thermistor_sense_off} = 4'h0;
      plug_kind = 3'h0;
      cyc(2);
      sys_rst = 1'b0;
      t_config;
      {thermistor_variant, port_cfg_sel_hi, port_cfg_sel_lo} = 3'h7;
      t_attach(3'h1, 1'b1, 1'b0, 2'h0);
      t_attach(3'h2, 1'b1, 1'b1, 2'h0);
      t_attach(3'h3, 1'b1, 1'b0, 2'h1);
      t_attach(3'h4, 1'b1, 1'b1, 2'h2);
      t_attach(3'h5, 1'b0, 1'b0, 2'h0);
      t_attach(3'h6, 1'b0, 1'b0, 2'h0);
      t_attach(3'h7, 1'b0, 1'b0, 2'h0);
      t_thermal;
      results;
   end
   // Whole run is about 25000 cycles; allow more than twice that
   initial begin
      #(60000 * 50);
      n_mismatch++;
      results;
   end
endmodule
